// ---- rtl/usc_ctrl.v ----
// Control and configuration registers of the serial transceiver, AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`include "usc_map.vh"

module usc_ctrl (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  input  wire        rx_complete_flag,
  input  wire        tx_complete_flag,
  input  wire        tx_buffer_empty_flag,
  input  wire        rx_start_flag,
  input  wire        sync_field_error_flag,
  output reg         rx_complete_irq,
  output reg         tx_complete_irq,
  output reg         tx_buffer_empty_irq,
  output reg         rx_start_irq,
  output reg         autobaud_error_irq,
  input  wire [8:0]  rx_data,
  output reg         rx_advance,
  output reg  [8:0]  tx_data,
  output reg         tx_advance,
  input  wire        rxd_in,
  input  wire        tx_serial,
  output reg         rx_serial,
  output reg         txd_out,
  output reg         txd_oe,
  output reg         rs485_mode,
  output reg         receiver_on,
  output reg         transmitter_on,
  output reg         frame_start_detect_enable,
  output reg         multi_node_mode,
  output reg         double_speed,
  output reg         generic_autobaud,
  output reg         lin_constrained_autobaud,
  output reg  [1:0]  comm_mode_select,
  output reg         host_spi_mode,
  output reg         infrared_mode,
  output reg         sync_mode,
  output reg         parity_enable,
  output reg         parity_odd,
  output reg         stop_bit_count,
  output reg  [3:0]  data_bits,
  output reg         nine_bit_low_first,
  output reg         nine_bit_high_first,
  output reg         spi_lsb_first,
  output reg         spi_sample_trailing
);

  // Byte that moves the data buffer for a given character size
  function adv_on_high;
    input [2:0] size;
    begin
      adv_on_high = (size == `USC_CS_9_LOW);
    end
  endfunction

  // Word index from a byte address; upper address bits must be zero
  function [8:0] word_index;
    input [31:0] addr;
    begin
      if (addr[31:10] != 22'h0 || addr[1:0] != 2'h0) begin
        word_index = 9'h1ff;
      end else begin
        word_index = {1'b0, addr[9:2]};
      end
    end
  endfunction

  reg  [7:0] irq_line;
  reg  [7:0] enable_receiver_speed_select;
  reg  [7:0] frame_format;
  reg        wr_pend;
  reg        rd_pend;
  reg  [8:0] acc_idx;
  reg  [31:0] next_rdata;

  wire       take = hsel & hready & htrans[1];
  wire [2:0] char_size = frame_format[2:0];
  wire [1:0] mode_field = frame_format[7:6];

  // Address phase capture; reads get one wait state so that a write just
  // before them is already visible in the returned word
  always @(posedge clk) begin
    if (!rst_n) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      acc_idx   <= 9'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      if (take) begin
        wr_pend <= hwrite;
        rd_pend <= ~hwrite;
        acc_idx <= word_index(haddr);
        hreadyout <= hwrite;
      end else if (hready) begin
        wr_pend <= 1'b0;
        rd_pend <= 1'b0;
        hreadyout <= 1'b1;
      end else begin
        wr_pend <= 1'b0;
        rd_pend <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  // Read mux for the single wait cycle
  always @* begin
    next_rdata = 32'h00000000;
    if (acc_idx == {1'b0, `USC_IDX_RX_LOW}) begin
      next_rdata = {24'h000000, rx_data[7:0]};
    end else if (acc_idx == {1'b0, `USC_IDX_RX_HIGH}) begin
      next_rdata = {31'h0, rx_data[8]};
    end else if (acc_idx == {1'b0, `USC_IDX_TX_LOW}) begin
      next_rdata = {24'h000000, tx_data[7:0]};
    end else if (acc_idx == {1'b0, `USC_IDX_TX_HIGH}) begin
      next_rdata = {31'h0, tx_data[8]};
    end else if (acc_idx == {1'b0, `USC_IDX_IRQ_LINE}) begin
      next_rdata = {24'h000000, irq_line};
    end else if (acc_idx == {1'b0, `USC_IDX_ENABLE_RECEIVER_SPEED_SELECT}) begin
      next_rdata = {24'h000000, enable_receiver_speed_select};
    end else if (acc_idx == {1'b0, `USC_IDX_FRAME_FORMAT}) begin
      // Host SPI layout shows only mode, data order and clock phase
      if (mode_field == `USC_CM_HOST_SPI) begin
        next_rdata = {24'h000000, frame_format & 8'hc6};
      end else begin
        next_rdata = {24'h000000, frame_format};
      end
    end else if (acc_idx == {1'b0, `USC_IDX_EVENT_STATUS}) begin
      next_rdata = {22'h0,
                    rx_complete_irq, tx_complete_irq, tx_buffer_empty_irq,
                    rx_start_irq, autobaud_error_irq,
                    rx_complete_flag, tx_complete_flag, tx_buffer_empty_flag,
                    rx_start_flag, sync_field_error_flag};
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend) begin
      hrdata <= next_rdata;
    end
  end

  // Register writes in the data phase
  always @(posedge clk) begin
    if (!rst_n) begin
      irq_line      <= `USC_RST_IRQ_LINE;
      enable_receiver_speed_select <= `USC_RST_ENABLE_RECEIVER_SPEED_SELECT;
      frame_format  <= `USC_RST_FRAME_FORMAT;
      tx_data       <= 9'h000;
    end else if (wr_pend) begin
      if (acc_idx == {1'b0, `USC_IDX_IRQ_LINE}) begin
        irq_line <= hwdata[7:0] & `USC_MASK_IRQ_LINE;
      end else if (acc_idx == {1'b0, `USC_IDX_ENABLE_RECEIVER_SPEED_SELECT}) begin
        enable_receiver_speed_select <= hwdata[7:0] & `USC_MASK_ENABLE_RECEIVER_SPEED_SELECT;
      end else if (acc_idx == {1'b0, `USC_IDX_FRAME_FORMAT}) begin
        frame_format <= hwdata[7:0];
      end else if (acc_idx == {1'b0, `USC_IDX_TX_LOW}) begin
        tx_data[7:0] <= hwdata[7:0];
      end else if (acc_idx == {1'b0, `USC_IDX_TX_HIGH}) begin
        tx_data[8] <= hwdata[0];
      end
    end
  end

  // Buffer advance strobes, one cycle wide
  always @(posedge clk) begin
    if (!rst_n) begin
      rx_advance <= 1'b0;
      tx_advance <= 1'b0;
    end else begin
      rx_advance <= 1'b0;
      tx_advance <= 1'b0;
      if (rd_pend) begin
        if (adv_on_high(char_size)) begin
          rx_advance <= (acc_idx == {1'b0, `USC_IDX_RX_HIGH});
        end else begin
          rx_advance <= (acc_idx == {1'b0, `USC_IDX_RX_LOW});
        end
      end
      if (wr_pend) begin
        if (adv_on_high(char_size)) begin
          tx_advance <= (acc_idx == {1'b0, `USC_IDX_TX_HIGH});
        end else begin
          tx_advance <= (acc_idx == {1'b0, `USC_IDX_TX_LOW});
        end
      end
    end
  end

  // Interrupt requests follow enable and flag as levels
  always @(posedge clk) begin
    if (!rst_n) begin
      rx_complete_irq     <= 1'b0;
      tx_complete_irq     <= 1'b0;
      tx_buffer_empty_irq <= 1'b0;
      rx_start_irq        <= 1'b0;
      autobaud_error_irq  <= 1'b0;
    end else begin
      rx_complete_irq     <= irq_line[`USC_BIT_RXC_IE] & rx_complete_flag;
      tx_complete_irq     <= irq_line[`USC_BIT_TXC_IE] & tx_complete_flag;
      tx_buffer_empty_irq <= irq_line[`USC_BIT_DRE_IE] & tx_buffer_empty_flag;
      rx_start_irq        <= irq_line[`USC_BIT_RXS_IE] & rx_start_flag;
      autobaud_error_irq  <= irq_line[`USC_BIT_ABE_IE] & sync_field_error_flag;
    end
  end

  // Serial line steering; idle level is high on both lines
  always @(posedge clk) begin
    if (!rst_n) begin
      rx_serial <= 1'b1;
      txd_out   <= 1'b1;
      txd_oe    <= 1'b0;
    end else begin
      if (!enable_receiver_speed_select[`USC_BIT_RX_ON]) begin
        rx_serial <= 1'b1;
      end else if (irq_line[`USC_BIT_LOOPBACK]) begin
        rx_serial <= tx_serial;
      end else begin
        rx_serial <= rxd_in;
      end
      // Pin keeps driving in loop-back so frames stay visible outside
      txd_out <= enable_receiver_speed_select[`USC_BIT_TX_ON] ? tx_serial : 1'b1;
      if (!enable_receiver_speed_select[`USC_BIT_TX_ON]) begin
        txd_oe <= 1'b0;
      end else if (enable_receiver_speed_select[`USC_BIT_OPEN_DRN]) begin
        // Only a low is driven, so a shared one-wire line is never fought
        txd_oe <= ~tx_serial;
      end else begin
        txd_oe <= 1'b1;
      end
    end
  end

  // Decoded configuration towards the engines
  always @(posedge clk) begin
    if (!rst_n) begin
      rs485_mode                <= 1'b0;
      receiver_on               <= 1'b0;
      transmitter_on            <= 1'b0;
      frame_start_detect_enable <= 1'b0;
      multi_node_mode           <= 1'b0;
      double_speed              <= 1'b0;
      generic_autobaud          <= 1'b0;
      lin_constrained_autobaud  <= 1'b0;
      comm_mode_select          <= `USC_CM_ASYNC;
      host_spi_mode             <= 1'b0;
      infrared_mode             <= 1'b0;
      sync_mode                 <= 1'b0;
      parity_enable             <= 1'b0;
      parity_odd                <= 1'b0;
      stop_bit_count            <= 1'b0;
      data_bits                 <= 4'h8;
      nine_bit_low_first        <= 1'b0;
      nine_bit_high_first       <= 1'b0;
      spi_lsb_first             <= 1'b0;
      spi_sample_trailing       <= 1'b0;
    end else begin
      rs485_mode <= irq_line[`USC_BIT_RS485];
      receiver_on <= enable_receiver_speed_select[`USC_BIT_RX_ON];
      transmitter_on <= enable_receiver_speed_select[`USC_BIT_TX_ON];
      frame_start_detect_enable <= enable_receiver_speed_select[`USC_BIT_SFD_EN];
      multi_node_mode <= enable_receiver_speed_select[`USC_BIT_MULTINODE];
      // Speed modes are passed as written; keeping them normal in
      // async and infrared is left to software
      double_speed <= (enable_receiver_speed_select[2:1] == `USC_RXM_DOUBLE);
      generic_autobaud <= (enable_receiver_speed_select[2:1] == `USC_RXM_GENERIC);
      lin_constrained_autobaud <= (enable_receiver_speed_select[2:1] == `USC_RXM_LIN);
      comm_mode_select <= mode_field;
      host_spi_mode <= (mode_field == `USC_CM_HOST_SPI);
      infrared_mode <= (mode_field == `USC_CM_INFRARED);
      sync_mode <= (mode_field == `USC_CM_SYNC);
      if (mode_field == `USC_CM_HOST_SPI) begin
        parity_enable       <= 1'b0;
        parity_odd          <= 1'b0;
        stop_bit_count      <= 1'b0;
        data_bits           <= 4'h8;
        nine_bit_low_first  <= 1'b0;
        nine_bit_high_first <= 1'b0;
        spi_lsb_first       <= frame_format[2];
        spi_sample_trailing <= frame_format[1];
      end else begin
        // Reserved parity code behaves as parity disabled
        parity_enable <= (frame_format[5:4] == `USC_PAR_EVEN) |
                         (frame_format[5:4] == `USC_PAR_ODD);
        parity_odd <= (frame_format[5:4] == `USC_PAR_ODD);
        stop_bit_count <= frame_format[3];
        // Reserved sizes fall back to eight bits
        if (char_size[2] == 1'b0) begin
          data_bits <= {1'b0, char_size} + 4'h5;
        end else if (char_size[1] == 1'b1) begin
          data_bits <= 4'h9;
        end else begin
          data_bits <= 4'h8;
        end
        nine_bit_low_first  <= (char_size == `USC_CS_9_LOW);
        nine_bit_high_first <= (char_size == `USC_CS_9_HIGH);
        spi_lsb_first       <= 1'b0;
        spi_sample_trailing <= 1'b0;
      end
    end
  end

endmodule

// ---- rtl/usc_map.vh ----
// Register map, field positions and reset values of the serial control block
`ifndef USC_MAP_VH
`define USC_MAP_VH

// Register indices; byte address is four times the index
`define USC_IDX_RX_LOW        8'h00
`define USC_IDX_RX_HIGH       8'h01
`define USC_IDX_TX_LOW        8'h02
`define USC_IDX_TX_HIGH       8'h03
`define USC_IDX_IRQ_LINE      8'h05
`define USC_IDX_ENABLE_RECEIVER_SPEED_SELECT 8'h06
`define USC_IDX_FRAME_FORMAT  8'h07
`define USC_IDX_EVENT_STATUS  8'h10

// Reset values
`define USC_RST_IRQ_LINE      8'h00
`define USC_RST_ENABLE_RECEIVER_SPEED_SELECT 8'h00
`define USC_RST_FRAME_FORMAT  8'h03

// Writable bit masks; masked bits are reserved and read as zero
`define USC_MASK_IRQ_LINE      8'hfd
`define USC_MASK_ENABLE_RECEIVER_SPEED_SELECT 8'hdf

// Interrupt and line control fields
`define USC_BIT_RXC_IE   7
`define USC_BIT_TXC_IE   6
`define USC_BIT_DRE_IE   5
`define USC_BIT_RXS_IE   4
`define USC_BIT_LOOPBACK 3
`define USC_BIT_ABE_IE   2
`define USC_BIT_RS485    0

// Enable and receiver mode fields
`define USC_BIT_RX_ON     7
`define USC_BIT_TX_ON     6
`define USC_BIT_SFD_EN    4
`define USC_BIT_OPEN_DRN  3
`define USC_BIT_MULTINODE 0

// Encodings
`define USC_RXM_NORMAL   2'h0
`define USC_RXM_DOUBLE   2'h1
`define USC_RXM_GENERIC  2'h2
`define USC_RXM_LIN      2'h3
`define USC_CM_ASYNC     2'h0
`define USC_CM_SYNC      2'h1
`define USC_CM_INFRARED  2'h2
`define USC_CM_HOST_SPI  2'h3
`define USC_PAR_EVEN     2'h2
`define USC_PAR_ODD      2'h3
`define USC_CS_9_LOW     3'h6
`define USC_CS_9_HIGH    3'h7

`endif

// ---- verification/usc_ctrl_checker.sv ----
// Assertion checker for the serial control block
`timescale 1ns/1ps
module usc_ctrl_checker (
  input wire       clk,
  input wire       rst_n,
  input wire       rx_complete_flag,
  input wire       tx_complete_flag,
  input wire       tx_buffer_empty_flag,
  input wire       rx_start_flag,
  input wire       sync_field_error_flag,
  input wire       rx_complete_irq,
  input wire       tx_complete_irq,
  input wire       tx_buffer_empty_irq,
  input wire       rx_start_irq,
  input wire       autobaud_error_irq,
  input wire       receiver_on,
  input wire       rx_serial,
  input wire       transmitter_on,
  input wire       txd_out,
  input wire       txd_oe,
  input wire       double_speed,
  input wire       generic_autobaud,
  input wire       lin_constrained_autobaud,
  input wire       host_spi_mode,
  input wire       parity_enable,
  input wire [3:0] data_bits,
  input wire       tx_advance
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rxc_irq_cause: assert property (rx_complete_irq |-> $past(rx_complete_flag))
    else $error("receive irq without its flag");
  a_txc_irq_cause: assert property (tx_complete_irq |-> $past(tx_complete_flag))
    else $error("transmit irq without its flag");
  a_dre_irq_cause: assert property (tx_buffer_empty_irq |-> $past(tx_buffer_empty_flag))
    else $error("empty irq without its flag");
  a_rxs_irq_cause: assert property (rx_start_irq |-> $past(rx_start_flag))
    else $error("start irq without its flag");
  a_abe_irq_cause: assert property (autobaud_error_irq |-> $past(sync_field_error_flag))
    else $error("autobaud irq without its flag");
  // Two cycles off so the registered path has settled
  a_rx_off_idle: assert property (!receiver_on && $past(!receiver_on) |-> rx_serial)
    else $error("receiver input not idle while off");
  a_tx_off_release: assert property (!transmitter_on && $past(!transmitter_on)
    |-> !txd_oe && txd_out)
    else $error("pin driven while transmitter off");
  a_speed_one_hot: assert property ($onehot0({double_speed, generic_autobaud,
    lin_constrained_autobaud}))
    else $error("speed decode not one hot");
  a_spi_frame_fixed: assert property (host_spi_mode |-> !parity_enable && data_bits == 4'h8)
    else $error("frame fields live in host spi mode");
  a_size_range: assert property (data_bits inside {[4'h5:4'h9]})
    else $error("data bit count out of range");
  a_adv_one_pulse: assert property (tx_advance |=> !tx_advance)
    else $error("transmit advance longer than one cycle");
endmodule

bind usc_ctrl usc_ctrl_checker i_usc_ctrl_checker (.*);

// ---- verification/usc_ctrl_tb.sv ----
// Self-checking testbench of the serial control block
`timescale 1ns/1ps
module usc_ctrl_tb;
  logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, send_en, send_bit;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans, comm_mode_select;
  logic [2:0]  hsize;
  logic [8:0]  rx_data, tx_data;
  logic [3:0]  data_bits;
  logic [4:0]  flags;
  logic rx_complete_flag, tx_complete_flag, tx_buffer_empty_flag, rx_start_flag;
  logic sync_field_error_flag, rx_complete_irq, tx_complete_irq, tx_buffer_empty_irq;
  logic rx_start_irq, autobaud_error_irq, rx_advance, tx_advance, rxd_in, tx_serial;
  logic rx_serial, txd_out, txd_oe, rs485_mode, receiver_on, transmitter_on, line_seen;
  logic frame_start_detect_enable, multi_node_mode, double_speed, generic_autobaud;
  logic lin_constrained_autobaud, host_spi_mode, infrared_mode, sync_mode, parity_enable;
  logic parity_odd, stop_bit_count, nine_bit_low_first, nine_bit_high_first;
  logic spi_lsb_first, spi_sample_trailing;
  int          errors, comparisons, i, t0, r0, tx_pulses, rx_pulses;
  logic [7:0]  en_bits [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04};

  assign hready = hreadyout;
  assign {rx_complete_flag, tx_complete_flag, tx_buffer_empty_flag, rx_start_flag,
          sync_field_error_flag} = flags;

  usc_ctrl i_usc_ctrl (.*);
  usc_remote_node i_usc_remote_node (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (tx_advance === 1'b1) tx_pulses++;
    if (rx_advance === 1'b1) rx_pulses++;
  end

  task automatic print_verdict;
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input [31:0] seen, input [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for hready; a hang counts as a mismatch
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        print_verdict();
      end
      @(posedge clk);
    end
  endtask

  task automatic xfer(input [7:0] idx, input w, input [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rv = hrdata;
  endtask

  task automatic wr(input [7:0] idx, input [31:0] d);
    xfer(idx, 1'b1, d);
    repeat (2) @(posedge clk);
  endtask

  task automatic rdc(input [7:0] idx, input [31:0] exp);
    xfer(idx, 1'b0, 32'h0);
    chk(rv, exp);
  endtask

  initial begin
    {hsel, hwrite, send_en, send_bit, tx_serial, rst_n} = 6'h0;
    {htrans, haddr, hwdata, flags} = '0;
    hsize = 3'h2;
    rx_data = 9'h1a5;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(8'h05, 32'h00);
    rdc(8'h06, 32'h00);
    rdc(8'h07, 32'h03);
    rdc(8'h08, 32'h00);
    wr(8'h05, 32'hff);
    rdc(8'h05, 32'hfd);
    chk(rs485_mode, 1);
    // Speed modes other than normal are only legal outside async and infrared
    wr(8'h07, 32'h43);
    wr(8'h06, 32'hff);
    rdc(8'h06, 32'hdf);
    wr(8'h06, 32'hd9);
    chk({receiver_on, transmitter_on, frame_start_detect_enable, multi_node_mode}, 4'hf);
    wr(8'h05, 32'h08);
    chk(rs485_mode, 0);
    send_en <= 1'b1;
    send_bit <= 1'b1;
    repeat (2) @(posedge clk);
    chk({rx_serial, txd_out, txd_oe, line_seen}, 4'h2);
    tx_serial <= 1'b1;
    send_bit <= 1'b0;
    repeat (2) @(posedge clk);
    chk({rx_serial, txd_oe, line_seen}, 3'h5);
    wr(8'h05, 32'h00);
    chk(rx_serial, 0);
    wr(8'h06, 32'h00);
    chk({rx_serial, txd_oe, txd_out}, 3'h5);
    for (i = 0; i < 4; i++) begin
      wr(8'h06, i << 1);
      chk({lin_constrained_autobaud, generic_autobaud, double_speed}, (3'h1 << i) >> 1);
    end
    wr(8'h06, 32'h00);
    flags <= 5'h1f;
    for (i = 0; i < 5; i++) begin
      wr(8'h05, en_bits[i]);
      chk({rx_complete_irq, tx_complete_irq, tx_buffer_empty_irq, rx_start_irq,
           autobaud_error_irq}, 5'h10 >> i);
    end
    rdc(8'h10, 32'h03f);
    wr(8'h05, 32'hf4);
    flags <= 5'h00;
    repeat (2) @(posedge clk);
    chk({rx_complete_irq, tx_complete_irq, tx_buffer_empty_irq, rx_start_irq,
         autobaud_error_irq}, 5'h00);
    for (i = 0; i < 3; i++) begin
      wr(8'h07, (i << 6) | 3);
      chk({comm_mode_select, infrared_mode, sync_mode}, {i[1:0], i == 2, i == 1});
    end
    for (i = 0; i < 4; i++) begin
      wr(8'h07, (i << 4) | (i[0] << 3) | 3);
      chk({parity_enable, parity_odd, stop_bit_count}, {i > 1, i == 3, i[0]});
    end
    for (i = 0; i < 8; i++) begin
      wr(8'h07, i);
      chk({data_bits, nine_bit_low_first, nine_bit_high_first},
          {i < 4 ? i[3:0] + 4'h5 : i < 6 ? 4'h8 : 4'h9, i == 6, i == 7});
    end
    wr(8'h07, 32'hfe);
    rdc(8'h07, 32'hc6);
    chk({host_spi_mode, spi_lsb_first, spi_sample_trailing, data_bits}, 7'h78);
    // Nine-bit low-first: the high byte moves the buffers
    wr(8'h07, 32'h06);
    t0 = tx_pulses;
    r0 = rx_pulses;
    wr(8'h02, 32'ha5);
    chk(tx_pulses, t0);
    wr(8'h03, 32'h01);
    chk(tx_pulses, t0 + 1);
    chk(tx_data, 9'h1a5);
    rdc(8'h00, 32'ha5);
    chk(rx_pulses, r0);
    rdc(8'h01, 32'h01);
    repeat (2) @(posedge clk);
    chk(rx_pulses, r0 + 1);
    wr(8'h07, 32'h03);
    wr(8'h02, 32'h3c);
    chk(tx_pulses, t0 + 2);
    rdc(8'h00, 32'ha5);
    repeat (2) @(posedge clk);
    chk(rx_pulses, r0 + 2);
    print_verdict();
  end
endmodule

// ---- verification/usc_remote_node.sv ----
// Remote serial node model on the receive and transmit lines
`timescale 1ns/1ps
module usc_remote_node (
  input  wire  send_en,
  input  wire  send_bit,
  input  wire  txd_out,
  input  wire  txd_oe,
  output logic rxd_in,
  output logic line_seen
);
  // Pulled-up line idles high whenever nobody drives it
  assign rxd_in    = send_en ? send_bit : 1'b1;
  assign line_seen = txd_oe ? txd_out : 1'b1;
endmodule
